// file: src/calib_mode_map.svh
// Constants for the calibration-read, mode-set and impedance-calibration block.
// Assumes inclusion by bare name from the design files.
`ifndef CALIB_MODE_MAP_SVH
`define CALIB_MODE_MAP_SVH
// Command encodings {cs_b, ras_b, cas_b, we_b}
`define CMD_MRS 4'h0
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_ZQ 4'h6
// Mode register 3 fields
`define MR3_EN_BIT 2
`define MR3_MODE_HI 1
`define MR3_MODE_LO 0
`define MPR_MODE_CAL 2'h0
`define MR_SEL_MR0 3'h0
`define MR_SEL_MR1 3'h1
`define MR_SEL_MR2 3'h2
`define MR_SEL_MR3 3'h3
// Mode register 0 and 1 fields
`define MR0_BL_HI 1
`define MR0_BL_LO 0
`define MR0_CL_HI 6
`define MR0_CL_LO 4
`define MR1_AL_HI 4
`define MR1_AL_LO 3
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_FIX4 2'h2
// Address bits of meaning
`define ADDR_BC_BIT 12
`define ADDR_NIB_BIT 2
`define ADDR_AP_BIT 10
// Calibration pattern, beat 0 in the LSB
`define CAL_PATTERN 8'haa
// Reset value of mode registers
`define MR_RESET 14'h0000
// Impedance calibration durations in link clock cycles
`define ZQ_LONG_CK 16'h0200
`define ZQ_SHORT_CK 16'h0040
// Cycle count reserve for latency
`define CL_BASE 5'h04
`endif

// file: src/calib_mode_pkg.sv
// Types for the calibration-read and mode-set block.
// Assumes the constants header is included where numbers are needed.
package calib_mode_pkg;
   typedef struct packed {
      logic cs_b;
      logic ras_b;
      logic cas_b;
      logic we_b;
      logic cke;
      logic [2:0] ba;
      logic [13:0] addr;
   } cmd_t;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BURST} rd_state_t;
   typedef enum logic [1:0] {ZQ_OFF, ZQ_LONG, ZQ_SHORT} zq_state_t;
endpackage : calib_mode_pkg

// file: src/calib_mode_ctl.sv
// Device-side logic: mode register set, pattern-register reads, impedance calibration.
// Assumes the link clock and command pins come from the controller's clock domain
// and are sampled here on mclk; one data beat is presented per link clock rising edge.
`timescale 1ns/1ps
`include "calib_mode_map.svh"
module calib_mode_ctl #(
   parameter int DQ_W = 16 // Data lines
) (
   input wire logic mclk, // 100 MHz system clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic link_ck, // Link clock from controller
   input wire calib_mode_pkg::cmd_t cmd_in, // Command pins
   input wire logic all_lines, // High: pattern on all data lines
   output logic [DQ_W-1:0] dq_out, // Data out
   output logic [DQ_W-1:0] dq_oe_b, // Data output enable, low drives
   output logic mpr_on, // Pattern mode active
   output logic mpr_rfu, // Reserved pattern mode selected
   output logic zq_busy, // Impedance calibration running
   output logic zq_long, // Running calibration is the long one
   output logic [13:0] mr0_val, // Mode register 0
   output logic [13:0] mr1_val, // Mode register 1
   output logic [13:0] mr2_val, // Mode register 2
   output logic [13:0] mr3_val // Mode register 3
);
   initial begin
      if (DQ_W < 1 || DQ_W > 64) $error("DQ_W out of range");
   end

   typedef struct packed {
      logic [2:0] ck_sync;
      calib_mode_pkg::cmd_t cmd_s1;
      calib_mode_pkg::cmd_t cmd_s2;
      logic [13:0] mr0;
      logic [13:0] mr1;
      logic [13:0] mr2;
      logic [13:0] mr3;
      calib_mode_pkg::rd_state_t rd;
      logic [4:0] lat;
      logic [2:0] beat;
      logic [2:0] last;
      logic [DQ_W-1:0] dq;
      logic [DQ_W-1:0] oe_b;
      calib_mode_pkg::zq_state_t zq;
      logic [15:0] zq_cnt;
      logic al_s1; // Line-select pin, first sync stage
      logic al_s2; // Line-select pin, second sync stage
      logic rfu; // Reserved pattern mode flag
      logic busy; // Calibration running flag
      logic lng; // Long calibration flag
   } state_t;

   state_t s;
   state_t next_s;

   logic ck_rise;
   logic [3:0] cmd_code;
   logic [4:0] rl;
   logic bc4;
   logic [7:0] pat;

   // Decode on the synchronised copies; the first stage is read only by the second
   always_comb begin
      ck_rise = s.ck_sync[1] & ~s.ck_sync[2];
      cmd_code = {s.cmd_s2.cs_b, s.cmd_s2.ras_b, s.cmd_s2.cas_b, s.cmd_s2.we_b};
      // Read latency is AL plus CL; AL uses the CL-1/CL-2 encoding
      rl = 5'(s.mr0[`MR0_CL_HI:`MR0_CL_LO]) + `CL_BASE;
      case (s.mr1[`MR1_AL_HI:`MR1_AL_LO])
         2'h1: rl = rl + rl - 5'h01;
         2'h2: rl = rl + rl - 5'h02;
         default: rl = rl;
      endcase
      // Burst length by mode register or on the fly through A12
      case (s.mr0[`MR0_BL_HI:`MR0_BL_LO])
         `BL_FIX4: bc4 = 1'b1;
         `BL_OTF: bc4 = ~s.cmd_s2.addr[`ADDR_BC_BIT];
         default: bc4 = 1'b0;
      endcase
      pat = `CAL_PATTERN;
   end

   always_comb begin
      next_s = s;
      next_s.ck_sync = {s.ck_sync[1:0], link_ck};
      next_s.cmd_s1 = cmd_in;
      next_s.cmd_s2 = s.cmd_s1;
      // The line-select strap is a pin too, so it gets the same two stages
      next_s.al_s1 = all_lines;
      next_s.al_s2 = s.al_s1;
      if (ck_rise) begin
         // Commands are taken on link clock rising edges only
         if (cmd_code == `CMD_MRS && s.cmd_s2.cke) begin
            case (s.cmd_s2.ba)
               `MR_SEL_MR0: next_s.mr0 = s.cmd_s2.addr;
               `MR_SEL_MR1: next_s.mr1 = s.cmd_s2.addr;
               `MR_SEL_MR2: next_s.mr2 = s.cmd_s2.addr;
               `MR_SEL_MR3: next_s.mr3 = s.cmd_s2.addr;
               default: next_s.mr0 = s.mr0;
            endcase
         end
         // Pattern read: only A2 and A12 matter, the rest are ignored
         if (cmd_code == `CMD_READ && s.cmd_s2.cke && s.mr3[`MR3_EN_BIT]
               && s.mr3[`MR3_MODE_HI:`MR3_MODE_LO] == `MPR_MODE_CAL) begin
            next_s.rd = calib_mode_pkg::ST_WAIT;
            // Burst state is entered rl-1 edges after the command, one edge before the first beat is registered at rl edges
            next_s.lat = rl - 5'h02;
            next_s.beat = (bc4 && s.cmd_s2.addr[`ADDR_NIB_BIT]) ? 3'h4 : 3'h0;
            next_s.last = (bc4 && s.cmd_s2.addr[`ADDR_NIB_BIT]) ? 3'h7 :
               (bc4 ? 3'h3 : 3'h7);
         end
         if (cmd_code == `CMD_ZQ && s.cmd_s2.cke && s.zq == calib_mode_pkg::ZQ_OFF) begin
            // A10 high selects the long calibration
            next_s.zq = s.cmd_s2.addr[`ADDR_AP_BIT] ? calib_mode_pkg::ZQ_LONG
               : calib_mode_pkg::ZQ_SHORT;
            next_s.zq_cnt = s.cmd_s2.addr[`ADDR_AP_BIT] ? `ZQ_LONG_CK : `ZQ_SHORT_CK;
         end
      end
      // Read pipeline steps once per link clock rising edge
      if (ck_rise) begin
         case (s.rd)
            calib_mode_pkg::ST_IDLE: begin
               next_s.oe_b = '1;
               next_s.dq = '0;
            end
            calib_mode_pkg::ST_WAIT: begin
               if (s.lat == 5'h00 || next_s.lat == 5'h00) next_s.rd = calib_mode_pkg::ST_BURST;
               else next_s.lat = s.lat - 5'h01;
            end
            calib_mode_pkg::ST_BURST: begin
               // Beat index picks the pattern bit: beat 0 is the LSB
               next_s.dq = s.al_s2 ? {DQ_W{pat[s.beat]}}
                  : {{(DQ_W-1){1'b0}}, pat[s.beat]};
               next_s.oe_b = '0;
               if (s.beat == s.last) next_s.rd = calib_mode_pkg::ST_IDLE;
               else next_s.beat = s.beat + 3'h1;
            end
            default: next_s.rd = calib_mode_pkg::ST_IDLE;
         endcase
         // Calibration timer counts link cycles; the bus stays released meanwhile
         if (s.zq != calib_mode_pkg::ZQ_OFF) begin
            if (s.zq_cnt == 16'h0001) next_s.zq = calib_mode_pkg::ZQ_OFF;
            next_s.zq_cnt = s.zq_cnt - 16'h0001;
         end
      end
      // Release follows the next calibration state so flag and bus move together
      if (next_s.zq != calib_mode_pkg::ZQ_OFF) next_s.oe_b = '1;
      // Status flags registered so every output comes from a flop
      next_s.rfu = next_s.mr3[`MR3_EN_BIT]
         & (next_s.mr3[`MR3_MODE_HI:`MR3_MODE_LO] != `MPR_MODE_CAL);
      next_s.busy = (next_s.zq != calib_mode_pkg::ZQ_OFF);
      next_s.lng = (next_s.zq == calib_mode_pkg::ZQ_LONG);
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s <= '0;
         s.mr0 <= `MR_RESET;
         s.mr1 <= `MR_RESET;
         s.mr2 <= `MR_RESET;
         s.mr3 <= `MR_RESET;
         s.oe_b <= '1;
         s.rd <= calib_mode_pkg::ST_IDLE;
         s.zq <= calib_mode_pkg::ZQ_OFF;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state flops
   assign dq_out = s.dq;
   assign dq_oe_b = s.oe_b;
   assign mpr_on = s.mr3[`MR3_EN_BIT];
   assign mpr_rfu = s.rfu;
   assign zq_busy = s.busy;
   assign zq_long = s.lng;
   assign mr0_val = s.mr0;
   assign mr1_val = s.mr1;
   assign mr2_val = s.mr2;
   assign mr3_val = s.mr3;

   property p_mrs_mr3;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && cmd_code == `CMD_MRS && s.cmd_s2.cke && s.cmd_s2.ba == `MR_SEL_MR3)
      |=> (s.mr3 == $past(s.cmd_s2.addr));
   endproperty
   a_mrs_mr3: assert property (p_mrs_mr3) else $error("MR3 not loaded");

   property p_no_drive_off;
      @(posedge mclk) disable iff (!rst_b)
      (!s.mr3[`MR3_EN_BIT] && s.rd == calib_mode_pkg::ST_IDLE)
      |=> (s.rd == calib_mode_pkg::ST_IDLE);
   endproperty
   a_no_drive_off: assert property (p_no_drive_off) else $error("Unexpected");

   property p_zq_quiet;
      @(posedge mclk) disable iff (!rst_b)
      zq_busy |-> (dq_oe_b == '1);
   endproperty
   a_zq_quiet: assert property (p_zq_quiet) else $error("Bus driven in calibration");

   property p_prime_only;
      @(posedge mclk) disable iff (!rst_b)
      (!s.al_s2 && dq_oe_b == '0 && DQ_W > 1) |-> (dq_out[DQ_W-1:1] == '0);
   endproperty
   a_prime_only: assert property (p_prime_only) else $error("Upper lines not low");

   property p_rfu_no_read;
      @(posedge mclk) disable iff (!rst_b)
      (mpr_rfu && s.rd == calib_mode_pkg::ST_IDLE) |=> (s.rd == calib_mode_pkg::ST_IDLE);
   endproperty
   a_rfu_no_read: assert property (p_rfu_no_read) else $error("Read in reserved mode");

   property p_bc4_hi;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && s.rd == calib_mode_pkg::ST_BURST && s.beat >= 3'h4) |=>
         (s.beat >= 3'h4 || s.rd != calib_mode_pkg::ST_BURST);
   endproperty
   a_bc4_hi: assert property (p_bc4_hi) else $error("Nibble order broken");

   property p_pattern;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && s.rd == calib_mode_pkg::ST_BURST) |=> (dq_out[0] == $past(s.beat[0]));
   endproperty
   a_pattern: assert property (p_pattern) else $error("Pattern bit wrong");

   property p_zq_end;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && zq_busy && s.zq_cnt == 16'h0001) |=> !zq_busy;
   endproperty
   a_zq_end: assert property (p_zq_end) else $error("Calibration did not end");

   // A pattern read in calibration mode starts the latency wait when the read pipeline is idle
   property p_rd_take;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && cmd_code == `CMD_READ && s.cmd_s2.cke && s.mr3[`MR3_EN_BIT]
         && s.mr3[`MR3_MODE_HI:`MR3_MODE_LO] == `MPR_MODE_CAL)
      |=> (s.rd == calib_mode_pkg::ST_WAIT && s.lat == $past(rl) - 5'h02);
   endproperty
   a_rd_take: assert property (p_rd_take) else $error("Pattern read not started");

   // Reads with pattern mode off never reach the pattern path
   property p_rd_ignore;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && cmd_code == `CMD_READ && !s.mr3[`MR3_EN_BIT]
         && s.rd == calib_mode_pkg::ST_IDLE) |=> (s.rd == calib_mode_pkg::ST_IDLE);
   endproperty
   a_rd_ignore: assert property (p_rd_ignore) else $error("Array read served pattern");

   // Chop read with A2 high covers the upper nibble only
   property p_nib_hi;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && cmd_code == `CMD_READ && s.cmd_s2.cke && s.mr3[`MR3_EN_BIT]
         && s.mr3[`MR3_MODE_HI:`MR3_MODE_LO] == `MPR_MODE_CAL && bc4
         && s.cmd_s2.addr[`ADDR_NIB_BIT]) |=> (s.beat == 3'h4 && s.last == 3'h7);
   endproperty
   a_nib_hi: assert property (p_nib_hi) else $error("Upper nibble bounds wrong");

   // Chop read with A2 low covers the lower nibble only
   property p_nib_lo;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && cmd_code == `CMD_READ && s.cmd_s2.cke && s.mr3[`MR3_EN_BIT]
         && s.mr3[`MR3_MODE_HI:`MR3_MODE_LO] == `MPR_MODE_CAL && bc4
         && !s.cmd_s2.addr[`ADDR_NIB_BIT]) |=> (s.beat == 3'h0 && s.last == 3'h3);
   endproperty
   a_nib_lo: assert property (p_nib_lo) else $error("Lower nibble bounds wrong");

   // Eight-beat read issued from the idle state runs beats zero to seven
   property p_full_burst;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && cmd_code == `CMD_READ && s.cmd_s2.cke && s.mr3[`MR3_EN_BIT]
         && s.mr3[`MR3_MODE_HI:`MR3_MODE_LO] == `MPR_MODE_CAL && !bc4)
      |=> (s.beat == 3'h0 && s.last == 3'h7);
   endproperty
   a_full_burst: assert property (p_full_burst) else $error("Eight-beat bounds wrong");

   // Every burst edge drives the bus unless calibration holds it released
   property p_burst_drive;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && s.rd == calib_mode_pkg::ST_BURST && !zq_busy
         && !(cmd_code == `CMD_ZQ && s.cmd_s2.cke)) |=> (dq_oe_b == '0);
   endproperty
   a_burst_drive: assert property (p_burst_drive) else $error("Beat not driven");

   // Idle link edges leave the data bus released
   property p_idle_release;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && s.rd == calib_mode_pkg::ST_IDLE) |=> (dq_oe_b == '1);
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("Bus driven when idle");

   // Calibration command picks its kind from A10 when the timer is free
   property p_zq_start;
      @(posedge mclk) disable iff (!rst_b)
      (ck_rise && cmd_code == `CMD_ZQ && s.cmd_s2.cke && !zq_busy)
      |=> (zq_busy && zq_long == $past(s.cmd_s2.addr[`ADDR_AP_BIT]));
   endproperty
   a_zq_start: assert property (p_zq_start) else $error("Calibration not started");
endmodule : calib_mode_ctl

// file: verification/calib_ctrl_model.sv
// Controller-side model: link clock and command pins of the calibration block.
// Assumes mclk drives it and the bench hands it one command at a time.
`timescale 1ns/1ps
module calib_ctrl_model (
   input wire logic mclk, // System clock
   input wire logic rst_b, // Sync reset, active low
   input wire logic go, // Bench request
   input wire calib_mode_pkg::cmd_t req, // Command to send
   output logic ack, // Request taken
   output logic smp, // Sample point in low phase
   output logic link_ck, // Link clock, 80 ns
   output calib_mode_pkg::cmd_t cmd_out // Command pins
);
   logic [2:0] ph;
   assign link_ck = (ph < 3'h4);
   // Commands change at the falling link edge and hold over the rise
   always_ff @(posedge mclk) begin
      ack <= 1'b0;
      smp <= (ph == 3'h5);
      ph <= rst_b ? ph + 3'h1 : 3'h0;
      if (!rst_b) begin
         cmd_out <= '{cs_b: 1'b1, cke: 1'b1, default: '0};
      end else if (ph == 3'h3 && go) begin
         // The bench always asks with CKE high; one rank, one calibration at a time
         cmd_out <= req;
         ack <= 1'b1;
      end else if (ph == 3'h3) begin
         // Deselect; address flips so a stale copy is never mistaken for data
         cmd_out.cs_b <= 1'b1;
         cmd_out.addr <= ~cmd_out.addr;
      end
   end
endmodule : calib_ctrl_model

// file: verification/tb_calib_mode_ctl.sv
// Bench for the calibration block: model of beats and latency against the pins.
// Assumes the controller model makes link clock and commands.
`timescale 1ns/1ps
`include "calib_mode_map.svh"
module tb_calib_mode_ctl;
   logic mclk = 0, rst_b = 0, go = 0, all_lines = 0, ack, smp, link_ck;
   calib_mode_pkg::cmd_t req = '{cs_b: 1'b1, default: '0}, cmd;
   logic [15:0] dq_out, dq_oe_b;
   logic mpr_on, mpr_rfu, zq_busy, zq_long;
   logic [13:0] mr [4];
   int fails = 0, total_checks = 0, m0 = 0, m1 = 0, k, n;
   calib_ctrl_model pm (.mclk(mclk), .rst_b(rst_b), .go(go), .req(req), .ack(ack),
      .smp(smp), .link_ck(link_ck), .cmd_out(cmd));
   calib_mode_ctl uut (.mclk(mclk), .rst_b(rst_b), .link_ck(link_ck), .cmd_in(cmd),
      .all_lines(all_lines), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .mpr_on(mpr_on),
      .mpr_rfu(mpr_rfu), .zq_busy(zq_busy), .zq_long(zq_long), .mr0_val(mr[0]),
      .mr1_val(mr[1]), .mr2_val(mr[2]), .mr3_val(mr[3]));
   initial forever #5 mclk = ~mclk;
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic wait_smp(int cnt);
      repeat (cnt) do @(posedge mclk); while (smp !== 1'b1);
   endtask : wait_smp
   // Hold the request until the model takes it, then let one edge pass
   task automatic issue(logic [3:0] c, logic [2:0] ba, logic [13:0] a);
      req <= '{cs_b: c[3], ras_b: c[2], cas_b: c[1], we_b: c[0], cke: 1'b1, ba: ba, addr: a};
      go <= 1'b1;
      do @(posedge mclk); while (ack !== 1'b1);
      go <= 1'b0;
      @(posedge mclk);
   endtask : issue
   task automatic mrs(int ba, logic [13:0] a);
      issue(`CMD_MRS, 3'(ba), a);
      if (ba == 0) m0 = a;
      if (ba == 1) m1 = a;
      wait_smp(4);
      check("mode register", {2'h0, mr[ba]}, {2'h0, a});
   endtask : mrs
   // Beats expected from burst mode, nibble and RL, compared at every link period
   task automatic rd(logic a12, logic a2, logic on);
      int len, first, cl, al, b, p;
      logic [13:0] a;
      len = ((m0 & 3) == 0 || ((m0 & 3) == 1 && a12)) ? 8 : 4;
      first = (len == 4 && a2) ? 4 : 0;
      cl = ((m0 >> 4) & 7) + 4;
      al = ((m1 >> 3) & 3) == 1 ? cl - 1 : (((m1 >> 3) & 3) == 2 ? cl - 2 : 0);
      // Ignored address bits above A2 and bank carry random junk
      a = (14'($urandom) & 14'h2ff8) | {1'b0, a12, 9'h0, a2, 2'h0};
      issue(`CMD_READ, 3'($urandom), a);
      wait_smp(1);
      for (int i = 0; i < al + cl + 10; i++) begin
         wait_smp(1);
         b = i - al - cl;
         p = (first + b) % 2;
         if (on && b >= 0 && b < len) begin
            check("drive", dq_oe_b, 16'h0);
            check("beat", dq_out, p ? (all_lines ? 16'hffff : 16'h1) : 16'h0);
         end else check("release", dq_oe_b, 16'hffff);
      end
   endtask : rd
   initial begin
      #400000;
      fails++;
      give_verdict();
   end
   initial begin
      k = $urandom(16);
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (6) @(posedge mclk);
      check("reset enable", dq_oe_b, 16'hffff);
      check("reset mr3", {2'h0, mr[3]}, 16'h0);
      mrs(0, 14'(($urandom % 4) << 4));
      mrs(1, 14'(($urandom % 3) << 3));
      mrs(2, 14'($urandom));
      rd(1'b1, 1'b0, 1'b0);
      mrs(3, 14'h0004);
      check("mpr on", {15'h0, mpr_on}, 16'h1);
      $display("test mode set done");
      for (k = 0; k < 2; k++) begin
         all_lines <= k[0];
         rd(1'b0, 1'b0, 1'b1);
      end
      mrs(0, 14'(m0 | 1));
      rd(1'b1, 1'b0, 1'b1);
      rd(1'b0, 1'b1, 1'b1);
      mrs(0, 14'(m0 ^ 3));
      rd(1'b0, 1'b1, 1'b1);
      rd(1'b0, 1'b0, 1'b1);
      $display("test pattern reads done");
      for (k = 1; k < 4; k++) begin
         mrs(3, 14'(4 + k));
         check("reserved", {15'h0, mpr_rfu}, 16'h1);
         rd(1'b1, 1'b0, 1'b0);
      end
      mrs(3, 14'h0000);
      $display("test reserved modes done");
      // Short then long calibration; the bus stays released while it runs
      for (k = 0; k < 2; k++) begin
         issue(`CMD_ZQ, 3'h0, k ? 14'h0400 : 14'h0000);
         wait_smp(2);
         check("zq busy", {15'h0, zq_busy}, 16'h1);
         check("zq kind", {15'h0, zq_long}, 16'(k));
         check("zq bus", dq_oe_b, 16'hffff);
         n = 0;
         while (zq_busy === 1'b1 && n < 600) begin
            wait_smp(1);
            n++;
         end
         check("zq span", 16'(n > (k ? 500 : 56) && n < (k ? 516 : 68)), 16'h1);
      end
      $display("test calibration done");
      give_verdict();
   end
endmodule : tb_calib_mode_ctl
